// file: dpsac_pkg.sv
// Constants and types for the PID, sleep and auxiliary drive control block
package dpsac_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int CTRL_PERIOD_NS  = 1_000_000;
  localparam int CTRL_PERIOD_CYC = CTRL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int ESTOP_UNIT_NS   = 100_000_000;
  localparam int ESTOP_UNIT_CYC  = ESTOP_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [2:0] USP_SETTLE_CYC = 3'h4;
  // ----------------------------------------------------------------
  // Register indices, byte address is index times four
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PI   = 4'h1;
  localparam logic [3:0] REG_DSP  = 4'h2;
  localparam logic [3:0] REG_LVL  = 4'h3;
  localparam logic [3:0] REG_DLY  = 4'h4;
  localparam logic [3:0] REG_AESA = 4'h5;
  localparam logic [3:0] REG_AESB = 4'h6;
  localparam logic [3:0] REG_STOP = 4'h7;
  localparam logic [3:0] REG_AO1  = 4'h8;
  localparam logic [3:0] REG_DIFN = 4'hA;
  localparam logic [3:0] REG_STAT = 4'hB;
  localparam int         REG_NUM  = 11;
  localparam logic [31:0] REG_RST [REG_NUM] = '{
    32'h0000_0080, 32'h0010_0200, 32'h0800_0000, 32'h0200_0100,
    32'h0064_0064, 32'h0004_1000, 32'h0E00_0B33, 32'h0199_0032,
    32'h0000_7D00, 32'h0000_7D00, 32'h320E_0706};
  localparam logic [31:0] REG_WMASK [REG_NUM] = '{
    32'h0000_03FF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
    32'hFFFF_FFFF, 32'h000F_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
    32'h7FFF_FFFF, 32'h7FFF_FFFF, 32'hFFFF_FFFF};
  // Control word fields
  localparam int PID_EN_BIT = 0;
  localparam int PID_NEG_BIT = 1;
  localparam int PID_DFB_BIT = 2;
  localparam int PID_ADD_BIT = 3;
  localparam int SLP_LSB = 4;
  localparam int AES_EN_BIT = 6;
  localparam int VF_BIT = 7;
  localparam int FBT_BIT = 8;
  localparam int CLS_BIT = 9;
  // Digital input function codes
  localparam logic [7:0] FN_JOG_FWD = 8'h06;
  localparam logic [7:0] FN_JOG_REV = 8'h07;
  localparam logic [7:0] FN_ESTOP   = 8'h0E;
  localparam logic [7:0] FN_SLEEP   = 8'h2F;
  localparam logic [7:0] FN_USP     = 8'h32;
  localparam logic [1:0] SLP_OFF    = 2'h0;
  localparam logic [1:0] SLP_LEVEL  = 2'h1;
  localparam logic [1:0] SLP_INPUT  = 2'h2;
  // Scaling, full scale is 0x1000
  localparam logic [15:0] FULL = 16'h1000;
  localparam logic signed [23:0] FULL_S = 24'sh001000;
  localparam logic signed [23:0] PID_LIM = 24'sh3FFFFF;
  localparam logic [12:0] FB_4MA_CODE = 13'h0333;
  localparam logic [12:0] VCLS_LO = 13'h08FC;
  localparam logic [12:0] VCLS_HI = 13'h11F8;
  localparam logic [10:0] RECIP_1000 = 11'h419;
  localparam logic [12:0] BIAS_MUL = 13'h10C7;
  localparam int BIAS_SH = 10;
  localparam logic [11:0] AO_MAX = 12'hFFF;
  localparam logic [4:0] AO_SRC_MAX = 5'h1B;
  localparam logic [27:0] AO_RSVD = 28'h0194000;
  localparam int SRC_PID_IN = 21;
  localparam int SRC_PID_OUT = 22;
  localparam int SRC_PID_TGT = 23;
  localparam int SRC_PID_FB = 24;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               rsvd;
    logic signed [11:0] bias;
    logic [13:0]        gain;
    logic [4:0]         sel;
  } dpsac_ao_cfg_type;
  typedef logic [27:0][15:0] dpsac_ao_src_type;
  typedef enum logic [1:0] {SLP_AWAKE = 2'b01, SLP_ASLEEP = 2'b10} dpsac_slp_type;
endpackage : dpsac_pkg

// file: dpsac_plant.sv
// Motor and feedback transducer model feeding the drive measurements
`timescale 1ns/1ps
`default_nettype none
module dpsac_plant (
  // Clock
  input  wire logic                   sys_clk,
  // Measurements towards the drive
  output logic [11:0]                 fb_adc,
  output logic [15:0]                 load_power,
  output logic [15:0]                 vf_volt,
  output dpsac_pkg::dpsac_ao_src_type meas
);
  import dpsac_pkg::*;
  logic [11:0] fb_r = 12'h000;
  // Odd sources sit at 100 percent, even ones at 0 percent
  always_comb for (int k = 0; k < 28; k++) meas[k] = k[0] ? FULL : 16'h0000;
  // Transducer sweeps its whole code range
  always @(posedge sys_clk) fb_r <= fb_r + 12'h001;
  assign fb_adc = fb_r;
  assign load_power = 16'h0400;
  assign vf_volt = 16'h0E60;
endmodule : dpsac_plant
`default_nettype wire

// file: dpsac_top.sv
// PID regulator, sleep, energy saving, halt, jog, start lockout and analog outputs
// Operation
// - V/F with energy saving on: trim voltage from measured load power
// - Energy saving voltage clamped to limit, 100% is 230V or 460V
// - Power filter time constant sets trim response speed
// - Filtered power compared with detection level to apply trim
// - Lower coefficient gives lower output voltage
// - Halt input ramps to zero over halt time, raises flag
// - Halt holds until run and halt input both drop
// - Input function 6 jogs forward, function 7 jogs reverse
// - Function 50 blocks start when run present at power-up
// - Each analog output picks source code 0 to 27
// - Gain 0 to 1000 percent, 100 percent is full scale
// - Bias -100 to 100 percent added at zero scale
// - Error is setpoint minus feedback times proportional gain
// - Mode bit 0 enables the regulator
// - Mode bit 1 inverts the regulator sign
// - Mode bit 2 takes derivative from error or feedback
// - Mode bit 3 adds target to regulator output
// - Feedback read as 0-10V or 4-20mA by type switch
// - Sleep mode 1: sleep after output below level for delay
// - Wake after output above wake level for delay
// - Sleep mode 0 off, mode 2 follows digital input
`timescale 1ns/1ps
`default_nettype none
module dpsac_top #(
  parameter int NUM_DI    = 4,
  parameter int CTRL_CYC  = dpsac_pkg::CTRL_PERIOD_CYC,
  parameter int ESTOP_CYC = dpsac_pkg::ESTOP_UNIT_CYC
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  // Register bus
  input  wire logic [5:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  // Terminal pins
  input  wire logic                        run_pin,
  input  wire logic [NUM_DI-1:0]           di_pin,
  // Drive measurements
  input  wire logic [11:0]                 fb_adc,
  input  wire logic [15:0]                 load_power,
  input  wire logic [15:0]                 vf_volt,
  input  wire dpsac_pkg::dpsac_ao_src_type meas,
  // Drive commands
  output logic [15:0]                      freq_ref,
  output logic [15:0]                      volt_cmd,
  output logic [11:0]                      analog_out_one,
  output logic [11:0]                      analog_out_two,
  output logic                             run_enable,
  output logic                             jog_fwd,
  output logic                             jog_rev,
  output logic                             emergency_halt_indication,
  output logic                             unattended_start_lockout,
  output logic                             pid_asleep
);
  import dpsac_pkg::*;

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [31:0] cfg_r [REG_NUM];
  logic [31:0] status;
  wire  [3:0]  widx   = avs_address[5:2];
  wire         req    = avs_read | avs_write;
  wire         wr_go  = avs_write & ack_r;
  wire         mapped = widx < 4'(REG_NUM);
  wire  [31:0] rd_word = (widx == REG_STAT) ? status : mapped ? cfg_r[widx] : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (avs_read & ~ack_r) rdata_r <= rd_word;
    end
  end
  assign avs_waitrequest = ~ack_r;
  assign avs_readdata    = rdata_r;

  for (genvar g = 0; g < REG_NUM; g++) begin : g_cfg
    always_ff @(posedge sys_clk) begin
      if (!resetn) cfg_r[g] <= REG_RST[g];
      else if (wr_go && widx == 4'(g)) cfg_r[g] <= avs_writedata & REG_WMASK[g];
    end
  end

  // Field decode
  wire        pid_en    = cfg_r[REG_CTRL][PID_EN_BIT];
  wire        pid_neg   = cfg_r[REG_CTRL][PID_NEG_BIT];
  wire        pid_dfb   = cfg_r[REG_CTRL][PID_DFB_BIT];
  wire        pid_add   = cfg_r[REG_CTRL][PID_ADD_BIT];
  wire [1:0]  slp_mode  = cfg_r[REG_CTRL][SLP_LSB +: 2];
  wire        aes_en    = cfg_r[REG_CTRL][AES_EN_BIT];
  wire        vf_mode   = cfg_r[REG_CTRL][VF_BIT];
  wire        fb_type   = cfg_r[REG_CTRL][FBT_BIT];
  wire        volt_cls  = cfg_r[REG_CTRL][CLS_BIT];
  wire [15:0] kp        = cfg_r[REG_PI][15:0];
  wire [15:0] ki        = cfg_r[REG_PI][31:16];
  wire [15:0] kd        = cfg_r[REG_DSP][15:0];
  wire [15:0] sp        = cfg_r[REG_DSP][31:16];
  wire [15:0] sleep_lvl = cfg_r[REG_LVL][15:0];
  wire [15:0] wake_lvl  = cfg_r[REG_LVL][31:16];
  wire [15:0] sleep_dly = cfg_r[REG_DLY][15:0];
  wire [15:0] wake_dly  = cfg_r[REG_DLY][31:16];
  wire [15:0] aes_vlim  = cfg_r[REG_AESA][15:0];
  wire [3:0]  aes_tc    = cfg_r[REG_AESA][19:16];
  wire [15:0] aes_det   = cfg_r[REG_AESB][15:0];
  wire [15:0] aes_coef  = cfg_r[REG_AESB][31:16];
  wire [15:0] stop_t    = cfg_r[REG_STOP][15:0];
  wire [15:0] jog_freq  = cfg_r[REG_STOP][31:16];
  wire [31:0] difn      = cfg_r[REG_DIFN];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [NUM_DI:0] s1_r;
  logic [NUM_DI:0] s2_r;
  logic [NUM_DI:0] s3_r;
  logic [NUM_DI:0] clean_r;
  wire  [NUM_DI:0] agree = ~(s2_r ^ s3_r);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      clean_r <= '0;
    end else begin
      s1_r    <= {run_pin, di_pin};
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      clean_r <= (agree & s3_r) | (~agree & clean_r);
    end
  end
  wire              run_on = clean_r[NUM_DI];
  wire [NUM_DI-1:0] di_on  = clean_r[NUM_DI-1:0];

  // Any input carrying the given function code and at the given level
  function automatic logic di_func(input logic [NUM_DI-1:0] lv, input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_DI; i++) hit = hit | (lv[i] & (difn[8*i +: 8] == code));
    return hit;
  endfunction : di_func

  wire est_in   = di_func(di_on, FN_ESTOP);
  wire jf_in    = di_func(di_on, FN_JOG_FWD);
  wire jr_in    = di_func(di_on, FN_JOG_REV);
  wire slp_in   = di_func(di_on, FN_SLEEP);
  wire usp_asgn = di_func({NUM_DI{1'b1}}, FN_USP);

  // ----------------------------------------------------------------
  // Control period tick
  // ----------------------------------------------------------------
  localparam int TW = $clog2(CTRL_CYC + 1);
  logic [TW-1:0] tcnt_r;
  logic          tick_r;
  wire           tcnt_end = tcnt_r == TW'(CTRL_CYC - 1);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tcnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= tcnt_end;
      tcnt_r <= tcnt_end ? '0 : tcnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // PID regulator
  // ----------------------------------------------------------------
  function automatic logic signed [23:0] sat(input logic signed [35:0] v);
    if (v > 36'(PID_LIM)) return PID_LIM;
    if (v < -36'(PID_LIM)) return -PID_LIM;
    return v[23:0];
  endfunction : sat

  logic signed [23:0] integ_r;
  logic signed [17:0] d_prev_r;
  logic [15:0]        pid_out_r;
  wire signed [13:0] fb_off = $signed({2'b00, fb_adc}) - $signed({1'b0, FB_4MA_CODE});
  wire [15:0] fb_cur = fb_off[13] ? 16'h0000 : {2'b00, fb_off} + {4'h0, fb_off[13:2]};
  wire [15:0] fb_val = fb_type ? fb_cur : {4'h0, fb_adc};
  wire signed [17:0] err   = $signed({2'b00, sp}) - $signed({2'b00, fb_val});
  wire signed [17:0] err_s = pid_neg ? -err : err;
  wire signed [17:0] d_src = pid_dfb ? -$signed({2'b00, fb_val}) : err_s;
  wire signed [34:0] p_prod = $signed({1'b0, kp}) * err_s;
  wire signed [34:0] i_prod = $signed({1'b0, ki}) * err_s;
  wire signed [18:0] d_diff = d_src - d_prev_r;
  wire signed [35:0] d_prod = $signed({1'b0, kd}) * d_diff;
  wire signed [23:0] p_term = sat(36'(p_prod >>> 8));
  wire signed [23:0] d_term = sat(d_prod >>> 8);
  wire signed [23:0] integ_nxt = sat(36'(integ_r) + 36'(i_prod >>> 8));
  wire signed [23:0] pid_sum = sat(36'(p_term) + 36'(integ_r) + 36'(d_term));
  wire signed [23:0] pid_res = pid_add ? sat(36'(pid_sum) + 36'($signed({2'b00, sp})))
                                       : pid_sum;
  wire [15:0] pid_nxt = pid_res < 0 ? 16'h0000 : pid_res > FULL_S ? FULL : pid_res[15:0];

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      integ_r   <= '0;
      d_prev_r  <= '0;
      pid_out_r <= 16'h0000;
    end else if (tick_r) begin
      integ_r   <= pid_en ? integ_nxt : '0;
      d_prev_r  <= pid_en ? d_src : '0;
      pid_out_r <= pid_en ? pid_nxt : sp;
    end
  end

  // ----------------------------------------------------------------
  // Sleep and wake-up
  // ----------------------------------------------------------------
  dpsac_slp_type slp_st_r;
  logic [15:0]   scnt_r;
  logic [15:0]   wcnt_r;
  wire        slp_cond = pid_out_r < sleep_lvl;
  wire        wk_cond  = pid_out_r > wake_lvl;
  wire [15:0] scnt_inc = (scnt_r == 16'hFFFF) ? scnt_r : scnt_r + 16'h0001;
  wire [15:0] wcnt_inc = (wcnt_r == 16'hFFFF) ? wcnt_r : wcnt_r + 16'h0001;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      slp_st_r <= SLP_AWAKE;
      scnt_r   <= 16'h0000;
      wcnt_r   <= 16'h0000;
    end else if (slp_mode != SLP_LEVEL) begin
      scnt_r   <= 16'h0000;
      wcnt_r   <= 16'h0000;
      slp_st_r <= (slp_mode == SLP_INPUT && slp_in) ? SLP_ASLEEP : SLP_AWAKE;
    end else if (tick_r) begin
      unique case (slp_st_r)
        SLP_AWAKE: begin
          scnt_r <= slp_cond ? scnt_inc : 16'h0000;
          wcnt_r <= 16'h0000;
          if (slp_cond && scnt_inc >= sleep_dly) slp_st_r <= SLP_ASLEEP;
        end
        SLP_ASLEEP: begin
          wcnt_r <= wk_cond ? wcnt_inc : 16'h0000;
          scnt_r <= 16'h0000;
          if (wk_cond && wcnt_inc >= wake_dly) slp_st_r <= SLP_AWAKE;
        end
      endcase
    end
  end
  wire asleep = slp_st_r == SLP_ASLEEP;

  // ----------------------------------------------------------------
  // Automatic energy saving
  // ----------------------------------------------------------------
  logic [15:0] pf_r;
  logic [15:0] volt_r;
  wire aes_on = vf_mode & aes_en;
  wire signed [16:0] pdiff = $signed({1'b0, load_power}) - $signed({1'b0, pf_r});
  wire signed [16:0] pstep = pdiff >>> aes_tc;
  wire [31:0] vtrim_p = vf_volt * aes_coef;
  wire [15:0] vtrim   = |vtrim_p[31:28] ? 16'hFFFF : vtrim_p[27:12];
  wire [28:0] vlim_p  = aes_vlim * (volt_cls ? VCLS_HI : VCLS_LO);
  wire [16:0] vlim_v  = vlim_p[28:12];
  wire [15:0] vopt    = (pf_r < aes_det) ? vtrim : vf_volt;
  wire [15:0] volt_nxt = !aes_on ? vf_volt
                       : ({1'b0, vopt} > vlim_v) ? vlim_v[15:0] : vopt;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pf_r   <= 16'h0000;
      volt_r <= 16'h0000;
    end else begin
      if (tick_r) pf_r <= 16'($signed({1'b0, pf_r}) + pstep);
      volt_r <= volt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Halt, jog, start lockout and frequency reference
  // ----------------------------------------------------------------
  logic        estop_r;
  logic        lock_r;
  logic        usp_done_r;
  logic [2:0]  usp_cnt_r;
  logic [39:0] acc_r;
  logic [15:0] freq_r;
  logic        run_en_r;
  logic        jogf_r;
  logic        jogr_r;
  wire [39:0] stop_span = 40'(stop_t) * 40'(ESTOP_CYC);
  wire [39:0] acc_inc   = acc_r + 40'(FULL);
  wire        step      = acc_inc >= stop_span;
  wire        jog_any   = jogf_r | jogr_r;
  wire [15:0] run_freq  = jog_any ? jog_freq : pid_en ? pid_out_r : sp;
  wire [15:0] halt_freq = (stop_span == 40'h0 || freq_r == 16'h0000) ? 16'h0000
                        : step ? freq_r - 16'h0001 : freq_r;
  wire        idle      = asleep | lock_r | ~(run_on | jog_any);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      estop_r    <= 1'b0;
      lock_r     <= 1'b0;
      usp_done_r <= 1'b0;
      usp_cnt_r  <= 3'h0;
      acc_r      <= 40'h0;
      freq_r     <= 16'h0000;
      run_en_r   <= 1'b0;
      jogf_r     <= 1'b0;
      jogr_r     <= 1'b0;
    end else begin
      estop_r <= est_in | (estop_r & run_on);
      if (!usp_done_r) begin
        usp_cnt_r  <= usp_cnt_r + 3'h1;
        usp_done_r <= usp_cnt_r == USP_SETTLE_CYC;
        lock_r     <= (usp_cnt_r == USP_SETTLE_CYC) & usp_asgn & run_on;
      end else begin
        lock_r <= lock_r & run_on;
      end
      acc_r    <= !estop_r ? 40'h0 : step ? acc_inc - stop_span : acc_inc;
      freq_r   <= estop_r ? halt_freq : idle ? 16'h0000 : run_freq;
      jogf_r   <= jf_in & ~estop_r & ~lock_r;
      jogr_r   <= jr_in & ~jf_in & ~estop_r & ~lock_r;
      run_en_r <= ~idle & ~(estop_r & freq_r == 16'h0000);
    end
  end

  // ----------------------------------------------------------------
  // Analog outputs
  // ----------------------------------------------------------------
  dpsac_ao_src_type src_all;
  logic [11:0]      ao_r [2];
  wire  [15:0]      pid_in_v = err_s[17] ? 16'h0000 : err_s[15:0];

  for (genvar k = 0; k < 28; k++) begin : g_src
    assign src_all[k] = AO_RSVD[k] ? 16'h0000 : (k == SRC_PID_IN) ? pid_in_v
                      : (k == SRC_PID_OUT) ? pid_out_r : (k == SRC_PID_TGT) ? sp
                      : (k == SRC_PID_FB) ? fb_val : meas[k];
  end

  for (genvar g = 0; g < 2; g++) begin : g_ao
    wire dpsac_ao_cfg_type ao_cfg = cfg_r[REG_AO1 + g];
    wire [15:0] src = (ao_cfg.sel <= AO_SRC_MAX) ? src_all[ao_cfg.sel] : 16'h0000;
    wire [29:0] gprod = src * ao_cfg.gain;
    wire [40:0] gsc = gprod * RECIP_1000;
    wire signed [25:0] bprod = ao_cfg.bias * $signed({1'b0, BIAS_MUL});
    wire signed [26:0] ao_sum = $signed({6'b0, gsc[40:20]}) + 27'(bprod >>> BIAS_SH);
    wire [11:0] ao_code = ao_sum < 0 ? 12'h000
                        : ao_sum > $signed({15'h0, AO_MAX}) ? AO_MAX : ao_sum[11:0];
    always_ff @(posedge sys_clk) begin
      if (!resetn) ao_r[g] <= 12'h000;
      else ao_r[g] <= ao_code;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and status
  // ----------------------------------------------------------------
  assign status = {pid_out_r, 7'h00, aes_on, asleep, lock_r, estop_r,
                   jogr_r, jogf_r, run_en_r, pid_en, run_on};
  assign freq_ref                  = freq_r;
  assign volt_cmd                  = volt_r;
  assign analog_out_one            = ao_r[0];
  assign analog_out_two            = ao_r[1];
  assign run_enable                = run_en_r;
  assign jog_fwd                   = jogf_r;
  assign jog_rev                   = jogr_r;
  assign emergency_halt_indication = estop_r;
  assign unattended_start_lockout  = lock_r;
  assign pid_asleep                = slp_st_r[1];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence bus_req_s;
    req && avs_waitrequest;
  endsequence
  sequence bus_ans_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  bus_answer_a: assert property (bus_req_s |=> bus_ans_s)
    else $error("bus answer not one cycle after request");
  halt_flag_a: assert property (est_in |=> emergency_halt_indication)
    else $error("halt flag not raised");
  halt_hold_a: assert property (estop_r && run_on |=> estop_r)
    else $error("halt released while run present");
  halt_zero_a: assert property (estop_r && stop_span == 40'h0 |=> freq_ref == 16'h0000)
    else $error("zero halt time did not stop");
  jog_out_a: assert property (jf_in && !estop_r && !lock_r |=> jog_fwd && !jog_rev)
    else $error("jog forward not followed");
  usp_hold_a: assert property (lock_r && run_on |=> lock_r ##1 !run_enable)
    else $error("lockout released with run held");
  pid_off_a: assert property (tick_r && !pid_en |=> integ_r == 0 && pid_out_r == $past(sp))
    else $error("disabled regulator not cleared");
  aes_clamp_a: assert property (aes_on |=> {1'b0, volt_cmd} <= $past(vlim_v))
    else $error("voltage above energy saving limit");
  aes_off_a: assert property (!aes_on |=> volt_cmd == $past(vf_volt))
    else $error("voltage trimmed with saving off");
  sleep_off_a: assert property (slp_mode == SLP_OFF |=> !pid_asleep)
    else $error("asleep with sleep disabled");
  sleep_enter_a: assert property (tick_r && slp_mode == SLP_LEVEL && !asleep && slp_cond
      && scnt_inc >= sleep_dly |=> pid_asleep)
    else $error("sleep not entered after delay");
endmodule : dpsac_top
`default_nettype wire

// file: dpsac_top_test.sv
// Self-checking bench for the PID, sleep and auxiliary drive control block
`timescale 1ns/1ps
`default_nettype none
module dpsac_top_test;
  import dpsac_pkg::*;
  logic        sys_clk = 0, resetn = 0, run_pin = 1, avs_read = 0, avs_write = 0;
  logic [5:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rnd, exp_q [$];
  logic [3:0]  di_pin = 4'h0;
  logic [11:0] fb_adc, analog_out_one, analog_out_two, obs [10];
  logic [15:0] load_power, vf_volt;
  logic        avs_waitrequest, jog_fwd, jog_rev, run_enable, pid_asleep;
  logic [15:0] freq_ref, volt_cmd;
  logic        emergency_halt_indication, unattended_start_lockout;
  dpsac_ao_src_type meas;
  int          num_errors = 0, n_checks = 0;
  always #25 sys_clk = ~sys_clk;
  dpsac_plant plant (.sys_clk, .fb_adc, .load_power, .vf_volt, .meas);
  dpsac_top #(.CTRL_CYC(8), .ESTOP_CYC(4)) dut (.sys_clk, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .run_pin, .di_pin, .fb_adc,
    .load_power, .vf_volt, .meas, .freq_ref, .volt_cmd, .analog_out_one,
    .analog_out_two, .run_enable, .jog_fwd, .jog_rev, .emergency_halt_indication,
    .unattended_start_lockout, .pid_asleep);
  always_comb obs = '{12'(jog_fwd), 12'(jog_rev), 12'(emergency_halt_indication),
    12'(unattended_start_lockout), analog_out_one, analog_out_two, 12'(run_enable),
    freq_ref[11:0], volt_cmd[11:0], 12'(pid_asleep)};
  task note(input string m);
    num_errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : note
  task stop_test();
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  // Bus cycle, entered just after a clock edge
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task expect_obs(input int k, input logic [11:0] v);
    int i;
    for (i = 0; i < 40 && obs[k] !== v; i++) @(posedge sys_clk);
    n_checks++;
    if (obs[k] !== v) note("output level");
  endtask : expect_obs
  // Read data monitor takes the oldest note
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      n_checks++;
      if (exp_q.size() == 0 || avs_readdata !== exp_q[0]) note("read data");
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(29));
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    expect_obs(3, 12'h001);
    rd(6'h00, 32'h0000_0080);
    rd(6'h30, 32'h0000_0000);
    bus(1'b1, 6'h00, 32'hFFFF_FFFF);
    rd(6'h00, 32'h0000_03FF);
    bus(1'b1, 6'h00, 32'h0000_0080);
    rnd = $urandom;
    bus(1'b1, 6'h04, rnd);
    rd(6'h04, rnd);
    run_pin <= 1'b0;
    expect_obs(3, 12'h000);
    di_pin <= 4'h1;
    expect_obs(0, 12'h001);
    expect_obs(6, 12'h001);
    expect_obs(7, 12'(REG_RST[7][31:16]));
    di_pin <= 4'h2;
    expect_obs(1, 12'h001);
    expect_obs(0, 12'h000);
    run_pin <= 1'b1;
    di_pin <= 4'h4;
    expect_obs(2, 12'h001);
    di_pin <= 4'h5;
    repeat (12) @(posedge sys_clk);
    expect_obs(0, 12'h000);
    di_pin <= 4'h0;
    repeat (12) @(posedge sys_clk);
    expect_obs(2, 12'h001);
    run_pin <= 1'b0;
    expect_obs(2, 12'h000);
    for (int k = 0; k < 28; k++) begin
      if (k < 21 || k > 24) begin
        bus(1'b1, 6'h20, 32'h0000_7D00 | 32'(k));
        bus(1'b1, 6'h24, 32'h0000_7D00 | 32'(k));
        expect_obs(4, (k % 2 == 1 && k != 19) ? 12'hFFF : 12'h000);
        expect_obs(5, (k % 2 == 1 && k != 19) ? 12'hFFF : 12'h000);
      end
    end
    bus(1'b1, 6'h20, 32'h0000_0001);
    expect_obs(4, 12'h000);
    bus(1'b1, 6'h00, 32'h0000_00C0);
    expect_obs(8, 12'(VCLS_LO));
    bus(1'b1, 6'h00, 32'h0000_02C0);
    expect_obs(8, 12'((32'h0000_0E60 * 32'(REG_RST[6][31:16])) >> 12));
    bus(1'b1, 6'h00, 32'h0000_0080);
    expect_obs(8, 12'hE60);
    bus(1'b1, 6'h28, 32'h320E_072F);
    bus(1'b1, 6'h00, 32'h0000_00A0);
    di_pin <= 4'h1;
    expect_obs(9, 12'h001);
    di_pin <= 4'h0;
    expect_obs(9, 12'h000);
    bus(1'b1, 6'h00, 32'h0000_0081);
    rd(6'h00, 32'h0000_0081);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    note("timeout");
    stop_test();
  end
endmodule : dpsac_top_test
`default_nettype wire
